// file: dv/disp_host_sva.sv
// Purpose: port checks for the display source
// Assumes: bench keeps i_suppress steady while busy
// Notes: bound into disp_host
`timescale 1ns/1ps
module disp_host_sva #(
    parameter int DIGITS = 4,
    parameter int FRAC = 0,
    parameter int CNT_W = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_suppress,
    input wire logic [CNT_W-1:0] i_dim_level,
    input wire logic [3:0] o_code,
    input wire logic [DIGITS-1:0] o_capture_gate_n,
    input wire logic [DIGITS-1:0] o_zero_blank_in_n,
    input wire logic [DIGITS-1:0] o_zero_blank_out_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic gating = !(&o_capture_gate_n);
    one_gate_a: assert property ($onehot0(~o_capture_gate_n)) else $error("two gates");
    code_hold_a: assert property (gating || $past(gating) |-> $stable(o_code))
        else $error("code moved");
    // nine low samples: the minimum gate width needs nine whole cycles
    gate_width_a: assert property ($rose(gating) |-> ##1 gating[*8])
        else $error("short gate");
    top_blank_a: assert property (gating |-> o_zero_blank_in_n[DIGITS-1] == !i_suppress)
        else $error("top blank");
    low_int_a: assert property (gating |-> o_zero_blank_in_n[FRAC]) else $error("low blank");
    dark_dim_a: assert property (i_dim_level == 0 && $past(i_dim_level) == 0 &&
        $past(i_dim_level, 2) == 0 |-> o_zero_blank_out_oe == 0) else $error("dim pulse");
    cover property ($rose(gating));
    cover property (gating && i_suppress);
    cover property ($rose(o_zero_blank_out_oe[0]));
endmodule
bind disp_host disp_host_sva #(.DIGITS(DIGITS), .FRAC(FRAC), .CNT_W(CNT_W)) disp_host_sva_inst (.*);

// file: dv/disp_host_tb.sv
// Purpose: self-checking bench for the display source
// Assumes: four digits, no fraction digits
// Notes: blank lines resolved here with pull-ups
`timescale 1ns/1ps
module disp_host_tb;
    localparam logic [6:0] LIT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F,
        7'h70, 7'h7F, 7'h7B, 7'h01, 7'h4F, 7'h37, 7'h0E, 7'h67, 7'h00};
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_load = 1'b0, i_suppress = 1'b0, o_busy;
    logic [15:0] i_value = 16'h0000;
    logic [7:0] i_dim_level = 8'h00;
    logic [3:0] o_code, gate_n, zb_in_n, zb_out_n, zb_oe, zb_line, zb_feed, pull;
    logic [6:0] seg_n [4];
    int err_count = 0, total_checks = 0, cycles = 0, hits;
    always #5 i_clk = ~i_clk;
    disp_host disp_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(i_load),
        .i_value(i_value), .i_suppress(i_suppress), .i_dim_level(i_dim_level),
        .o_busy(o_busy), .o_code(o_code), .o_capture_gate_n(gate_n), .o_zero_blank_in_n(zb_in_n),
        .o_zero_blank_out_n(zb_out_n), .o_zero_blank_out_oe(zb_oe));
    assign zb_line = ~(pull | (zb_oe & ~zb_out_n));
    assign zb_feed = zb_in_n | {1'b0, zb_line[3:1]};
    for (genvar k = 0; k < 4; k++) begin : dig
        seg_digit_model seg_digit_model_inst (.i_code(o_code), .i_capture_gate_n(gate_n[k]),
            .i_zero_blank_in_n(zb_feed[k]), .i_zero_blank_out_n(zb_line[k]),
            .o_seg_n(seg_n[k]), .o_zero_blank_pull(pull[k]));
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] want(input logic [15:0] v, input logic sup, input int k);
        logic lead = sup;
        for (int j = 3; j >= k; j--)
            if (v[4*j+:4] != 4'h0 || j == 0) lead = 1'b0;
        return lead ? 7'h7F : ~LIT[v[4*k+:4]];
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic show(input logic [15:0] v, input logic sup, input logic extra);
        i_value <= v;
        i_suppress <= sup;
        @(posedge i_clk);
        i_load <= 1'b1;
        @(posedge i_clk);
        i_load <= 1'b0;
        // a load while busy must be ignored
        repeat (4) @(posedge i_clk);
        i_load <= extra;
        @(posedge i_clk);
        i_load <= 1'b0;
        for (int n = 0; n < 300 && o_busy !== 1'b0; n++) @(negedge i_clk);
        for (int k = 0; k < 4; k++) check(seg_n[k], want(v, sup, k));
        @(posedge i_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        logic [15:0] corner [7] = '{16'h0000, 16'h0506, 16'h0060, 16'h3210, 16'h7654,
            16'hBA98, 16'hFEDC};
        void'($urandom(53));
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        foreach (corner[i]) show(corner[i], 1'b1, i == 1);
        foreach (corner[i]) show(corner[i], 1'b0, 1'b0);
        repeat (12) show(16'($urandom), 1'($urandom), 1'($urandom));
        i_dim_level <= 8'h80;
        repeat (4) @(posedge i_clk);
        hits = 0;
        repeat (512) begin
            @(negedge i_clk);
            if (zb_oe[0] === 1'b1) begin
                hits++;
                check(16'(seg_n[0]), 16'h007F);
            end
        end
        check(16'(hits), 16'h0100);
        report_and_stop();
    end
endmodule

// file: dv/seg_digit_model.sv
// Purpose: behavioural latch decoder digit
// Assumes: blank line resolved outside with a pull-up
// Notes: level-sensitive storage, no clock
`timescale 1ns/1ps
module seg_digit_model (
    input wire logic [3:0] i_code,
    input wire logic i_capture_gate_n,
    input wire logic i_zero_blank_in_n,
    input wire logic i_zero_blank_out_n,
    output logic [6:0] o_seg_n,
    output logic o_zero_blank_pull
);
    // segments a..g in bits 6..0, high means lit
    localparam logic [6:0] LIT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F,
        7'h70, 7'h7F, 7'h7B, 7'h01, 7'h4F, 7'h37, 7'h0E, 7'h67, 7'h00};
    logic [3:0] held; // unknown until first capture
    always_latch if (!i_capture_gate_n) held <= i_code;
    assign o_zero_blank_pull = (held == 4'h0) && !i_zero_blank_in_n;
    assign o_seg_n = (!i_zero_blank_out_n || o_zero_blank_pull) ? 7'h7F : ~LIT[held];
endmodule

// file: rtl/dim_pwm.sv
// Purpose: duty-cycle generator for blanking-based dimming
// Assumes: single clock
// Notes: high output means blank requested
`timescale 1ns/1ps
`include "disp_host_cfg.svh"
module dim_pwm #(
    parameter int CNT_W = `CNT_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [CNT_W-1:0] i_off_level,
    output logic o_blank
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_blank;

    always_comb begin
        next_cnt = cnt + 1'b1;
        next_blank = (cnt < i_off_level);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt <= '0;
            o_blank <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_blank <= next_blank;
        end
    end
endmodule

// file: rtl/disp_host.sv
// Purpose: multiplexing source driving a row of latch decoders
// Assumes: device outputs are not observed; i_load from same-clock logic
// Notes: chain pins are driven per digit for integer/fraction split
`timescale 1ns/1ps
`include "disp_host_cfg.svh"
module disp_host
    import disp_host_pkg::*;
#(
    parameter int DIGITS = `DIGITS_DEF,
    parameter int FRAC = 0,
    parameter int CNT_W = `CNT_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_load,
    input wire logic [DIGITS*4-1:0] i_value,
    input wire logic i_suppress,
    input wire logic [CNT_W-1:0] i_dim_level,
    output logic o_busy,
    output logic [3:0] o_code,
    output logic [DIGITS-1:0] o_capture_gate_n,
    output logic [DIGITS-1:0] o_zero_blank_in_n,
    output logic [DIGITS-1:0] o_zero_blank_out_n,
    output logic [DIGITS-1:0] o_zero_blank_out_oe
);
    localparam int IDX_W = (DIGITS > 1) ? $clog2(DIGITS) : 1;
    localparam logic [7:0] SETUP_CYC = 8'(`SETUP_CYC);
    localparam logic [7:0] GATE_CYC = 8'(`GATE_LOW_CYC);
    localparam logic [7:0] HOLD_CYC = 8'(`HOLD_CYC);

    ////////////////////////////////////////////////////////////////////////
    strobe_state_t state;
    strobe_state_t next_state;
    logic [7:0] tmr;
    logic [7:0] next_tmr;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] next_idx;
    logic [DIGITS*4-1:0] value;
    logic [DIGITS*4-1:0] next_value;
    logic [3:0] next_code;
    logic [DIGITS-1:0] next_gate_n;
    logic next_busy;
    digit_req_t req;
    logic dim_blank;

    dim_pwm #(
        .CNT_W(CNT_W)
    ) u_dim (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_off_level(i_dim_level),
        .o_blank(dim_blank)
    );

    always_comb begin
        req.code = value[idx*4 +: 4];
        req.last = (idx == IDX_W'(DIGITS - 1));
    end

    // one digit per strobe: code first, then only that gate low
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_idx = idx;
        next_value = value;
        next_code = o_code;
        next_gate_n = '1;
        case (state)
            ST_IDLE: begin
                if (i_load) begin
                    next_value = i_value;
                    next_idx = '0;
                    next_code = i_value[3:0];
                    next_tmr = SETUP_CYC;
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_code = req.code;
                if (tmr <= 8'h01) begin
                    next_tmr = GATE_CYC;
                    next_gate_n[idx] = 1'b0;
                    next_state = ST_GATE;
                end else begin
                    next_tmr = tmr - 8'h01;
                end
            end
            ST_GATE: begin
                if (tmr <= 8'h01) begin
                    // gate rises, code held for hold time
                    next_tmr = HOLD_CYC;
                    next_state = ST_HOLD;
                end else begin
                    next_gate_n[idx] = 1'b0;
                    next_tmr = tmr - 8'h01;
                end
            end
            ST_HOLD: begin
                if (tmr <= 8'h01) begin
                    if (req.last) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_idx = idx + 1'b1;
                        next_code = value[(idx + 1'b1)*4 +: 4];
                        next_tmr = SETUP_CYC;
                        next_state = ST_SETUP;
                    end
                end else begin
                    next_tmr = tmr - 8'h01;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_busy = (next_state != ST_IDLE);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            tmr <= 8'h00;
            idx <= '0;
            value <= '0;
            o_code <= 4'h0;
            o_capture_gate_n <= '1;
            o_busy <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            idx <= next_idx;
            value <= next_value;
            o_code <= next_code;
            o_capture_gate_n <= next_gate_n;
            o_busy <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // blanking pins; digit DIGITS-1 is most significant, FRAC lowest are fraction
    logic [DIGITS-1:0] next_rbi_n;
    logic [DIGITS-1:0] next_oe;

    always_comb begin
        for (int i = 0; i < DIGITS; i++) begin
            if (!i_suppress) begin
                next_rbi_n[i] = 1'b1;
            end else if (i == DIGITS - 1) begin
                next_rbi_n[i] = 1'b0;
            end else if (i == FRAC) begin
                next_rbi_n[i] = 1'b1;
            end else if (i > FRAC) begin
                // integer: drive blank-in low; the upper neighbour's blank-out chain is joined outside
                next_rbi_n[i] = 1'b0;
            end else begin
                // fraction: lowest digit heads the chain, the rest are fed from below
                next_rbi_n[i] = 1'b0;
            end
            // dimming overrides everything via blank-out
            next_oe[i] = dim_blank;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_zero_blank_in_n <= '1;
            o_zero_blank_out_oe <= '0;
            o_zero_blank_out_n <= '0;
        end else begin
            o_zero_blank_in_n <= next_rbi_n;
            o_zero_blank_out_oe <= next_oe;
            o_zero_blank_out_n <= '0;
        end
    end
endmodule

// file: rtl/disp_host_cfg.svh
// Purpose: constants for the multiplexed display source
// Assumes: 100 MHz clock
// Notes: times in ns, setup and gate counts derived from the clock rate
`ifndef DISP_HOST_CFG_SVH
`define DISP_HOST_CFG_SVH
`define CLK_PERIOD_NS 10
`define CODE_W 4
`define SETUP_NS 75
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GATE_LOW_NS 85
`define GATE_LOW_CYC ((`GATE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC 1
`define DIM_PERIOD_DEF 256
`define DIGITS_DEF 4
`define CNT_W 8
`endif

// file: rtl/disp_host_pkg.sv
// Purpose: types for the multiplexed display source
// Assumes: nothing
// Notes: one-hot strobe sequence
package disp_host_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_GATE = 4'h4,
        ST_HOLD = 4'h8
    } strobe_state_t;

    typedef struct packed {
        logic [3:0] code;
        logic last;
    } digit_req_t;
endpackage
